// ### common/dcspm_pkg.sv
/*
 * Constants for the device status word and the shared-pin multiplexer:
 * register offsets, strap vector layout, status field positions and pin roles.
 * Assumes the byte-addressed register port of the core and sixteen shared pins.
 */
package dcspm_pkg;

    // ****************************************************************
    // Register port
    // ****************************************************************
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFS_STATUS     = 8'h00;
    localparam logic [7:0]  OFS_GPIO_EN    = 8'h04;
    localparam logic [7:0]  OFS_GPIO_DIR   = 8'h08;
    localparam logic [7:0]  OFS_GPIO_OUT   = 8'h0c;
    localparam logic [7:0]  OFS_GPIO_IN    = 8'h10;

    // ****************************************************************
    // Strap vector layout
    // ****************************************************************
    localparam int          STRAP_W        = 11;
    localparam int          STRAP_PCI      = 0;
    localparam int          STRAP_ETH      = 1;
    localparam int          STRAP_HPW      = 2;
    localparam int          STRAP_PSI      = 3;
    localparam int          STRAP_MUL_LO   = 4;
    localparam int          STRAP_MUL_HI   = 5;
    localparam int          STRAP_BYTE_ORDER_STRAP     = 6;
    localparam int          STRAP_BOOT_LO  = 7;
    localparam int          STRAP_BOOT_HI  = 8;
    localparam int          STRAP_XCLK_LO  = 9;
    localparam int          STRAP_XCLK_HI  = 10;
    // Defaults: PCI off, x1, little endian, no boot, external memory clock input
    localparam logic [10:0] STRAP_DEFAULT  = 11'h040;
    // Edges after release before the synchronised straps are trusted
    localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

    // ****************************************************************
    // Status word fields
    // ****************************************************************
    localparam int          ST_XCLK_LSB    = 0;
    localparam int          ST_BOOT_LSB    = 2;
    localparam int          ST_BYTE_ORDER_STRAP        = 4;
    localparam int          ST_MUL_LSB     = 5;
    localparam int          ST_RSVD        = 7;
    localparam int          ST_PCI         = 8;
    localparam int          ST_PSI         = 9;
    localparam int          ST_HPW         = 10;
    localparam int          ST_ETH         = 11;
    localparam int          ST_USED_W      = 12;

    // ****************************************************************
    // Shared pins
    // ****************************************************************
    localparam int          PIN_N          = 16;
    localparam int          PIN_CLK4       = 1;
    localparam int          PIN_CLK6       = 2;
    localparam int          PIN_VIDEO_DAC_CTRL       = 8;
    localparam int          PIN_PCI_LO     = 9;
    localparam int          PCI_PIN_N      = 7;
    localparam logic [15:0] CLKOUT_MASK    = 16'h0006;
    localparam logic [15:0] VIDEO_DAC_CTRL_MASK      = 16'h0100;
    localparam logic [15:0] PCI_MASK       = 16'hfe00;

endpackage

// ### core/dcspm_pin_cell.sv
/*
 * One shared pin: picks GPIO or the alternate function, registers the pad
 * drive and enable, and synchronises the pad level with two flip-flops.
 * Assumes select inputs come from logic on clk; padIn comes from a pin.
 */
`timescale 1ns/100ps
`default_nettype none

module dcspm_pin_cell (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic gpioSel,
    input  wire logic gpioDir,
    input  wire logic gpioOut,
    input  wire logic altSel,
    input  wire logic altOut,
    input  wire logic altOe,
    input  wire logic padIn,
    output var  logic padOut,
    output var  logic padOe,
    output var  logic syncIn
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic out;
        logic oe;
    } dcspm_cell_t;

    dcspm_cell_t cur;
    dcspm_cell_t next_cur;

    always_comb begin
        next_cur      = cur;
        next_cur.meta = padIn;
        next_cur.sync = cur.meta;
        if (gpioSel) begin
            // Direction 0 is input, 1 is output
            next_cur.out = gpioOut;
            next_cur.oe  = gpioDir;
        end else if (altSel) begin
            next_cur.out = altOut;
            next_cur.oe  = altOe;
        end else begin
            // No owner: pin floats rather than fighting an external driver
            next_cur.out = 1'b0;
            next_cur.oe  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign padOut = cur.out;
    assign padOe  = cur.oe;
    assign syncIn = cur.sync;

endmodule

`default_nettype wire

// ### core/dcspm_core.sv
/*
 * Device status word latched from board straps after reset, plus the
 * shared-pin multiplexer with GPIO enable, direction and output registers.
 * Assumes straps are held steady by resistors around reset, alternate
 * functions come from logic on clk, and the register master never waits.
 */
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module dcspm_core (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output var  logic [31:0] rdData,
    input  wire logic        pciIdSelectStrap,
    input  wire logic        ethernetCtrlOn,
    input  wire logic        hostPortWidth,
    input  wire logic        pciSerialInit,
    input  wire logic        cpuMultSelHi,
    input  wire logic        cpuMultSelLo,
    input  wire logic        byteOrderStrap,
    input  wire logic        bootSrcHi,
    input  wire logic        bootSrcLo,
    input  wire logic        xmemClkSelHi,
    input  wire logic        xmemClkSelLo,
    output var  logic        pciOwnsPins,
    output var  logic        hostGroupOwnsPins,
    output var  logic        ethernetEnabled,
    input  wire logic        clockOutDiv4,
    input  wire logic        clockOutDiv6,
    input  wire logic        videoDacCtrl,
    input  wire logic [6:0]  pciPinOut,
    input  wire logic [6:0]  pciPinOe,
    output var  logic [6:0]  pciPinIn,
    input  wire logic [15:0] padIn,
    output var  logic [15:0] padOut,
    output var  logic [15:0] padOe
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [10:0] strapMeta;
        logic [10:0] strapSync;
        logic [1:0]  settle;
        logic        captured;
        logic [10:0] strapHeld;
        logic [15:0] gpioEn;
        logic [15:0] gpioDir;
        logic [15:0] gpioOut;
        logic [31:0] rdData;
        logic        pciOwn;
        logic        hostOwn;
        logic        ethOn;
    } dcspm_state_t;

    dcspm_state_t cur;
    dcspm_state_t next_cur;

    logic [10:0] strapPins;
    logic [31:0] statusWord;
    logic [15:0] syncIn;
    logic [15:0] gpioSel;
    logic [15:0] altSel;
    logic [15:0] altOut;
    logic [15:0] altOe;

    assign strapPins = {xmemClkSelHi, xmemClkSelLo, bootSrcHi, bootSrcLo, byteOrderStrap,
                        cpuMultSelHi, cpuMultSelLo, pciSerialInit, hostPortWidth,
                        ethernetCtrlOn, pciIdSelectStrap};

    // ****************************************************************
    // Status word
    // ****************************************************************
    always_comb begin
        statusWord = '0;
        statusWord[dcspm_pkg::ST_PCI] = cur.strapHeld[dcspm_pkg::STRAP_PCI];
        // Ethernet strap means nothing while PCI owns the shared pins
        statusWord[dcspm_pkg::ST_ETH] = cur.strapHeld[dcspm_pkg::STRAP_ETH]
                                      & ~cur.strapHeld[dcspm_pkg::STRAP_PCI];
        statusWord[dcspm_pkg::ST_HPW] = cur.strapHeld[dcspm_pkg::STRAP_HPW];
        statusWord[dcspm_pkg::ST_PSI] = cur.strapHeld[dcspm_pkg::STRAP_PSI]
                                      & cur.strapHeld[dcspm_pkg::STRAP_PCI];
        statusWord[dcspm_pkg::ST_RSVD] = 1'b0;
        statusWord[dcspm_pkg::ST_MUL_LSB +: 2] = {cur.strapHeld[dcspm_pkg::STRAP_MUL_HI],
                                                  cur.strapHeld[dcspm_pkg::STRAP_MUL_LO]};
        statusWord[dcspm_pkg::ST_BYTE_ORDER_STRAP] = cur.strapHeld[dcspm_pkg::STRAP_BYTE_ORDER_STRAP];
        statusWord[dcspm_pkg::ST_BOOT_LSB +: 2] = {cur.strapHeld[dcspm_pkg::STRAP_BOOT_HI],
                                                   cur.strapHeld[dcspm_pkg::STRAP_BOOT_LO]};
        statusWord[dcspm_pkg::ST_XCLK_LSB +: 2] = {cur.strapHeld[dcspm_pkg::STRAP_XCLK_HI],
                                                   cur.strapHeld[dcspm_pkg::STRAP_XCLK_LO]};
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_cur           = cur;
        next_cur.strapMeta = strapPins;
        next_cur.strapSync = cur.strapMeta;
        // Straps are sampled once after release, never again until reset
        if (!cur.captured) begin
            if (cur.settle == dcspm_pkg::STRAP_SETTLE) begin
                next_cur.strapHeld = cur.strapSync;
                next_cur.captured  = 1'b1;
            end else begin
                next_cur.settle = cur.settle + 2'h1;
            end
        end
        // Ownership follows the held PCI strap, so the groups never overlap
        next_cur.pciOwn  = cur.strapHeld[dcspm_pkg::STRAP_PCI];
        next_cur.hostOwn = ~cur.strapHeld[dcspm_pkg::STRAP_PCI];
        next_cur.ethOn   = cur.strapHeld[dcspm_pkg::STRAP_ETH]
                         & ~cur.strapHeld[dcspm_pkg::STRAP_PCI];
        // Writes to the status word fall through untouched
        if (wrStb) begin
            case (addr)
                dcspm_pkg::OFS_GPIO_EN:  next_cur.gpioEn  = wrData[15:0];
                dcspm_pkg::OFS_GPIO_DIR: next_cur.gpioDir = wrData[15:0];
                dcspm_pkg::OFS_GPIO_OUT: next_cur.gpioOut = wrData[15:0];
                default:                 next_cur.gpioEn  = cur.gpioEn;
            endcase
        end
        next_cur.rdData = '0;
        if (rdStb) begin
            case (addr)
                dcspm_pkg::OFS_STATUS:   next_cur.rdData = statusWord;
                dcspm_pkg::OFS_GPIO_EN:  next_cur.rdData = {16'h0000, cur.gpioEn};
                dcspm_pkg::OFS_GPIO_DIR: next_cur.rdData = {16'h0000, cur.gpioDir};
                dcspm_pkg::OFS_GPIO_OUT: next_cur.rdData = {16'h0000, cur.gpioOut};
                dcspm_pkg::OFS_GPIO_IN:  next_cur.rdData = {16'h0000, syncIn};
                default:                 next_cur.rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur           <= '0;
            cur.strapHeld <= dcspm_pkg::STRAP_DEFAULT;
            cur.hostOwn   <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************************************
    // Pin multiplexer
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < dcspm_pkg::PIN_N; i++) begin : g_pin
            if (dcspm_pkg::CLKOUT_MASK[i]) begin : g_clk
                assign gpioSel[i] = cur.gpioEn[i];
                assign altSel[i]  = ~cur.gpioEn[i];
                assign altOut[i]  = (i == dcspm_pkg::PIN_CLK4) ? clockOutDiv4 : clockOutDiv6;
                assign altOe[i]   = 1'b1;
            end else if (dcspm_pkg::VIDEO_DAC_CTRL_MASK[i]) begin : g_video_dac_ctrl
                assign gpioSel[i] = cur.gpioEn[i] & cur.hostOwn;
                assign altSel[i]  = ~gpioSel[i];
                assign altOut[i]  = videoDacCtrl;
                assign altOe[i]   = 1'b1;
            end else if (dcspm_pkg::PCI_MASK[i]) begin : g_pci
                assign gpioSel[i] = cur.gpioEn[i] & cur.hostOwn;
                assign altSel[i]  = cur.pciOwn;
                assign altOut[i]  = pciPinOut[i - dcspm_pkg::PIN_PCI_LO];
                assign altOe[i]   = pciPinOe[i - dcspm_pkg::PIN_PCI_LO];
            end else begin : g_plain
                assign gpioSel[i] = cur.gpioEn[i];
                assign altSel[i]  = 1'b0;
                assign altOut[i]  = 1'b0;
                assign altOe[i]   = 1'b0;
            end
            dcspm_pin_cell u_cell (
                .clk     (clk),
                .arst_n  (arst_n),
                .gpioSel (gpioSel[i]),
                .gpioDir (cur.gpioDir[i]),
                .gpioOut (cur.gpioOut[i]),
                .altSel  (altSel[i]),
                .altOut  (altOut[i]),
                .altOe   (altOe[i]),
                .padIn   (padIn[i]),
                .padOut  (padOut[i]),
                .padOe   (padOe[i]),
                .syncIn  (syncIn[i])
            );
        end
    endgenerate

    assign pciPinIn          = syncIn[15:9];
    assign rdData            = cur.rdData;
    assign pciOwnsPins       = cur.pciOwn;
    assign hostGroupOwnsPins = cur.hostOwn;
    assign ethernetEnabled   = cur.ethOn;

    // ****************************************************************
    // Checks
    // ****************************************************************
    status_rsvd_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdStb && addr == dcspm_pkg::OFS_STATUS |=> rdData[31:12] == '0 && !rdData[7])
        else $error("reserved status bits not zero");

    status_pci_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdStb && addr == dcspm_pkg::OFS_STATUS |=> rdData[8] == pciOwnsPins)
        else $error("PCI status bit disagrees with pin ownership");

    eth_gated_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdStb && addr == dcspm_pkg::OFS_STATUS && pciOwnsPins |=> !rdData[11] && !ethernetEnabled)
        else $error("ethernet shown on while PCI selected");

    serial_gated_a: assert property (@(posedge clk) disable iff (!arst_n)
        rdStb && addr == dcspm_pkg::OFS_STATUS && !statusWord[dcspm_pkg::ST_PCI] |=> !rdData[9])
        else $error("serial init shown without PCI");

    straps_held_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur.captured |=> $stable(cur.strapHeld) && cur.captured)
        else $error("straps changed after capture");

    owners_excl_a: assert property (@(posedge clk) disable iff (!arst_n)
        pciOwnsPins != hostGroupOwnsPins)
        else $error("pin ownership not exclusive");

    capture_time_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> ##[0:3] cur.captured)
        else $error("straps not captured in time");

    clk4_default_a: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && !cur.gpioEn[1] |=> padOe[1] && padOut[1] == $past(clockOutDiv4))
        else $error("clock output pin not driving clock");

    video_dac_ctrl_pci_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur.pciOwn |=> padOe[8] && padOut[8] == $past(videoDacCtrl))
        else $error("video DAC pin taken while PCI selected");

    gpio_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur.gpioEn[0] |=> padOe[0] == $past(cur.gpioDir[0]) && padOut[0] == $past(cur.gpioOut[0]))
        else $error("GPIO pin direction or level wrong");

    gp8_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
        cur.gpioEn[8] && cur.hostOwn && !cur.gpioDir[8] |=> !padOe[8])
        else $error("pin 8 drives while set as input");

endmodule

`default_nettype wire

// ### tb/dcspm_testbench.sv
/*
 * Self-checking bench for the status word and shared-pin multiplexer.
 * Assumes the core answers reads one cycle after the strobe and captures
 * straps a few edges after reset release.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;

    logic        clk;
    logic        arst_n;
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wrStb;
    logic        rdStb;
    logic [31:0] rdData;
    logic [10:0] strap;
    logic        pciOwnsPins;
    logic        hostGroupOwnsPins;
    logic        ethernetEnabled;
    logic        clockOutDiv4;
    logic        clockOutDiv6;
    logic        videoDacCtrl;
    logic [6:0]  pciPinOut;
    logic [6:0]  pciPinOe;
    logic [6:0]  pciPinIn;
    logic [15:0] padIn;
    logic [15:0] padOut;
    logic [15:0] padOe;
    int          fail_count;
    int          comparisons;

    dcspm_core dut (
        .clk               (clk),
        .arst_n            (arst_n),
        .addr              (addr),
        .wrData            (wrData),
        .wrStb             (wrStb),
        .rdStb             (rdStb),
        .rdData            (rdData),
        .pciIdSelectStrap  (strap[dcspm_pkg::STRAP_PCI]),
        .ethernetCtrlOn    (strap[dcspm_pkg::STRAP_ETH]),
        .hostPortWidth     (strap[dcspm_pkg::STRAP_HPW]),
        .pciSerialInit     (strap[dcspm_pkg::STRAP_PSI]),
        .cpuMultSelHi      (strap[dcspm_pkg::STRAP_MUL_HI]),
        .cpuMultSelLo      (strap[dcspm_pkg::STRAP_MUL_LO]),
        .byteOrderStrap    (strap[dcspm_pkg::STRAP_BYTE_ORDER_STRAP]),
        .bootSrcHi         (strap[dcspm_pkg::STRAP_BOOT_HI]),
        .bootSrcLo         (strap[dcspm_pkg::STRAP_BOOT_LO]),
        .xmemClkSelHi      (strap[dcspm_pkg::STRAP_XCLK_HI]),
        .xmemClkSelLo      (strap[dcspm_pkg::STRAP_XCLK_LO]),
        .pciOwnsPins       (pciOwnsPins),
        .hostGroupOwnsPins (hostGroupOwnsPins),
        .ethernetEnabled   (ethernetEnabled),
        .clockOutDiv4      (clockOutDiv4),
        .clockOutDiv6      (clockOutDiv6),
        .videoDacCtrl      (videoDacCtrl),
        .pciPinOut         (pciPinOut),
        .pciPinOe          (pciPinOe),
        .pciPinIn          (pciPinIn),
        .padIn             (padIn),
        .padOut            (padOut),
        .padOe             (padOe)
    );

    // ****************************************************************
    // Clock and shared tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Straps must stand from reset until well after capture
    task automatic do_reset(input logic [10:0] s, input int n);
        @(posedge clk);
        strap  <= s;
        arst_n <= 1'b0;
        repeat (n) @(posedge clk);
        arst_n <= 1'b1;
        cycles(8);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrStb  <= 1'b1;
        @(posedge clk);
        wrStb  <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1;
        d = rdData;
    endtask

    function automatic logic [31:0] exp_status(input logic [10:0] s);
        logic pci;
        pci = s[dcspm_pkg::STRAP_PCI];
        return {20'h00000, s[dcspm_pkg::STRAP_ETH] & ~pci, s[dcspm_pkg::STRAP_HPW],
                s[dcspm_pkg::STRAP_PSI] & pci, pci, 1'b0,
                s[dcspm_pkg::STRAP_MUL_HI], s[dcspm_pkg::STRAP_MUL_LO],
                s[dcspm_pkg::STRAP_BYTE_ORDER_STRAP], s[dcspm_pkg::STRAP_BOOT_HI],
                s[dcspm_pkg::STRAP_BOOT_LO], s[dcspm_pkg::STRAP_XCLK_HI],
                s[dcspm_pkg::STRAP_XCLK_LO]};
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        logic [31:0] d;
        reg_rd(dcspm_pkg::OFS_STATUS, d);
        chk(d, 32'h00000010, "default status");
        chk({31'h0, hostGroupOwnsPins}, {31'h0, ~pciOwnsPins}, "owners exclusive");
        chk({31'h0, pciOwnsPins}, 32'h0, "pci owner default");
    endtask

    // Every code of each two-bit field, eth and serial init under both PCI choices
    task automatic t_codes();
        logic [31:0] d;
        logic [10:0] s;
        for (int i = 0; i < 8; i++) begin
            s = {i[1:0], i[1:0], i[0], i[1:0], i[0], i[1], 1'b1, i[2]};
            do_reset(s, 2);
            reg_rd(dcspm_pkg::OFS_STATUS, d);
            chk(d, exp_status(s), "strap status");
            chk({31'h0, pciOwnsPins}, {31'h0, i[2]}, "pci owner");
            chk({31'h0, hostGroupOwnsPins}, {31'h0, ~i[2]}, "host owner");
            chk({31'h0, ethernetEnabled}, {31'h0, ~i[2]}, "ethernet on");
        end
    endtask

    task automatic t_readonly();
        logic [31:0] d;
        logic [31:0] e;
        do_reset(11'h2b5, 3);
        e = exp_status(11'h2b5);
        reg_wr(dcspm_pkg::OFS_STATUS, 32'hffffffff);
        @(posedge clk);
        strap <= 11'h000;
        cycles(6);
        reg_rd(dcspm_pkg::OFS_STATUS, d);
        chk(d, e, "status after write and strap change");
        cycles(0);
        @(posedge clk);
        #1;
        chk(rdData, 32'h0, "read data stands one cycle");
        reg_rd(8'h20, d);
        chk(d, 32'h0, "unmapped read");
    endtask

    task automatic t_pins();
        logic [31:0] d;
        do_reset(dcspm_pkg::STRAP_DEFAULT, 2);
        @(posedge clk);
        clockOutDiv4 <= 1'b1;
        clockOutDiv6 <= 1'b0;
        videoDacCtrl <= 1'b1;
        padIn        <= 16'h0104;
        cycles(3);
        chk({padOe[8], padOe[2:1], padOut[8], padOut[2:1]}, 32'h3d, "alternate pins");
        chk(padOe[15:9], 7'h00, "unowned pins idle");
        // Upper half written as ones: must be dropped by the 16-pin register
        reg_wr(dcspm_pkg::OFS_GPIO_EN, 32'hffff0106);
        reg_wr(dcspm_pkg::OFS_GPIO_DIR, 32'h00000002);
        reg_wr(dcspm_pkg::OFS_GPIO_OUT, 32'h00000002);
        reg_rd(dcspm_pkg::OFS_GPIO_EN, d);
        chk(d, 32'h00000106, "gpio enable readback");
        @(posedge clk);
        clockOutDiv4 <= 1'b0;
        cycles(3);
        chk({padOe[8], padOe[2:1], padOut[1]}, 32'h3, "gpio pins");
        reg_rd(dcspm_pkg::OFS_GPIO_IN, d);
        chk(d & 32'h0106, 32'h00000104, "gpio input read");
        reg_wr(dcspm_pkg::OFS_GPIO_DIR, 32'h00000100);
        reg_wr(dcspm_pkg::OFS_GPIO_OUT, 32'h00000100);
        cycles(3);
        chk({padOe[8], padOut[8], padOe[1]}, 32'h6, "pin 8 output");
    endtask

    task automatic t_pci();
        logic [31:0] d;
        do_reset(11'h041, 2);
        reg_wr(dcspm_pkg::OFS_GPIO_EN, 32'h0000ffff);
        reg_wr(dcspm_pkg::OFS_GPIO_DIR, 32'h0000ffff);
        reg_wr(dcspm_pkg::OFS_GPIO_OUT, 32'h00000000);
        reg_rd(dcspm_pkg::OFS_GPIO_DIR, d);
        chk(d, 32'h0000ffff, "gpio direction readback");
        reg_rd(dcspm_pkg::OFS_GPIO_OUT, d);
        chk(d, 32'h00000000, "gpio output readback");
        @(posedge clk);
        videoDacCtrl <= 1'b1;
        pciPinOe     <= 7'h55;
        pciPinOut    <= 7'h33;
        padIn        <= 16'h5400;
        cycles(4);
        chk({padOe[8], padOut[8]}, 32'h3, "pin 8 kept under pci");
        chk(padOe[15:9], 7'h55, "pci pin enable");
        chk(padOut[15:9], 7'h33, "pci pin drive");
        chk(pciPinIn, 7'h2a, "pci pin input");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        fail_count   = 0;
        comparisons  = 0;
        arst_n       = 1'b0;
        addr         = 8'h00;
        wrData       = 32'h0;
        wrStb        = 1'b0;
        rdStb        = 1'b0;
        strap        = dcspm_pkg::STRAP_DEFAULT;
        clockOutDiv4 = 1'b0;
        clockOutDiv6 = 1'b0;
        videoDacCtrl = 1'b0;
        pciPinOut    = 7'h00;
        pciPinOe     = 7'h00;
        padIn        = 16'h0000;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        cycles(8);
        t_defaults();
        t_codes();
        t_readonly();
        t_pins();
        t_pci();
        end_sim();
    end

endmodule

`default_nettype wire
